/* File: verilog/vcpu_ctl_pkg.sv */
// constants and types for the virtual cpu interface control block
package vcpu_ctl_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 13;
    localparam logic [12:0] OFS_CONTROL = 13'h0000;
    localparam logic [12:0] OFS_BINARY_POINT = 13'h0008;
    localparam logic [12:0] OFS_ACKNOWLEDGE = 13'h000C;
    localparam logic [12:0] OFS_END_OF_INT = 13'h0010;
    localparam logic [12:0] OFS_ALIASED_BP = 13'h001C;
    localparam logic [12:0] OFS_ALIASED_EOI = 13'h0024;
    localparam logic [12:0] OFS_DEACTIVATE = 13'h1000;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int BIT_GROUP0_EN = 0;
    localparam int BIT_GROUP1_EN = 1;
    localparam int BIT_ACK_CTL = 2;
    localparam int BIT_FAST_SEL = 3;
    localparam int BIT_SHARED_BP = 4;
    localparam int BIT_SPLIT_EOI = 9;
    localparam logic [31:0] CONTROL_WRITE_MASK = 32'h0000_021F;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // binary point values
    // ------------------------------------------------------------
    localparam logic [2:0] BP_RESET = 3'h2;
    localparam logic [2:0] BP_MIN = 3'h2;
    localparam logic [2:0] ABP_RESET = 3'h3;
    localparam logic [2:0] ABP_MIN = 3'h3;

    // ------------------------------------------------------------
    // identifiers and list entry states
    // ------------------------------------------------------------
    localparam logic [9:0] ID_SPURIOUS = 10'h3FF;
    localparam logic [9:0] ID_GROUP1_HELD = 10'h3FE;
    localparam logic [1:0] LR_INVALID = 2'h0;
    localparam logic [1:0] LR_PENDING = 2'h1;
    localparam logic [1:0] LR_ACTIVE = 2'h2;
    localparam logic [1:0] LR_ACT_PEND = 2'h3;

    typedef struct packed {
        logic hw;
        logic group;
        logic [1:0] state;
        logic [4:0] priority_level;
        logic [9:0] physical_id;
        logic [9:0] virtual_id;
    } list_entry_t;

    typedef struct packed {
        logic valid;
        logic hw;
        logic [9:0] id;
    } completion_t;

endpackage

/* File: verilog/pending_select.sv */
// picks the highest priority pending list entry among enabled groups
module pending_select
    import vcpu_ctl_pkg::*;
#(
    parameter int ENTRIES = 4,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    // list view
    input wire list_entry_t entries [ENTRIES],
    input wire logic [1:0] group_enable,
    // selection
    output logic hit,
    output logic [IDX_W-1:0] index,
    output logic group
);

    logic [4:0] best;

    always_comb begin
        hit = 1'b0;
        index = '0;
        group = 1'b0;
        best = 5'h1F;
        for (int i = 0; i < ENTRIES; i++) begin
            // group taken only from the entry's own group bit
            if (entries[i].state == LR_PENDING && group_enable[entries[i].group] &&
                (!hit || entries[i].priority_level < best)) begin
                hit = 1'b1;
                index = IDX_W'(i);
                group = entries[i].group;
                best = entries[i].priority_level;
            end
        end
    end

endmodule

/* File: verilog/virtual_cpu_if_control.sv */
// control register logic of a virtual cpu interface
// Functional notes
// - an interrupt is group 0 or group 1 only by the group bit of its list entry.
// - in split mode eoi writes only drop priority and deactivate writes only deactivate.
// - with split mode clear, an end-of-interrupt write drops priority and deactivates.
// - in split mode an end-of-interrupt write drops the running priority and leaves the entry active.
// - in split mode a deactivate write makes the entry inactive and sends a completion to the distributor; with split mode clear it is ignored.
// - shared binary point clear: group 1 uses the aliased one; set: it uses the main one.
// - the fast select bit routes group 0 to the virtual irq line at 0 and the fiq line at 1.
// - acknowledge control 0 with group 1 highest pending reads 1022 and changes nothing.
// - acknowledge control 1 with group 1 highest pending reads its id and makes it active.
// - active and pending is allowed only for entries that are not hardware linked.
// - the group 1 enable bit gates signalling of group 1 interrupts.
// - the group 0 enable bit gates signalling of group 0 interrupts.
// - with signalling disabled or nothing pending an acknowledge read returns 1023.
module virtual_cpu_if_control
    import vcpu_ctl_pkg::*;
#(
    parameter int ENTRIES = 4,
    parameter int IDX_W = $clog2(ENTRIES)
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // guest register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // hypervisor list port
    input wire logic lr_load,
    input wire logic [IDX_W-1:0] lr_index,
    input wire list_entry_t lr_data,
    input wire logic [IDX_W-1:0] lr_rd_index,
    output list_entry_t lr_rd_data,
    // signalling to the processor
    output logic virq,
    output logic vfiq,
    output logic [2:0] group0_bp,
    output logic [2:0] group1_bp,
    // distributor completion
    output completion_t completion
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] ctl_reg, ctl_next;
    logic [2:0] bp_reg, bp_next;
    logic [2:0] abp_reg, abp_next;
    list_entry_t lr_reg [ENTRIES];
    list_entry_t lr_next [ENTRIES];
    logic [ENTRIES-1:0] held_reg, held_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    list_entry_t lr_rd_reg, lr_rd_next;
    logic virq_reg, virq_next;
    logic vfiq_reg, vfiq_next;
    logic [2:0] g0bp_reg, g0bp_next;
    logic [2:0] g1bp_reg, g1bp_next;
    completion_t cmp_reg, cmp_next;

    logic sel_hit;
    logic [IDX_W-1:0] sel_idx;
    logic sel_group;
    logic [9:0] sel_id;
    logic eoi_wr, dir_wr, ack_rd;
    logic match_hit;
    logic [IDX_W-1:0] match_idx;

    // ------------------------------------------------------------
    // active entry lookup by id
    // ------------------------------------------------------------
    function automatic logic [IDX_W:0] find_active(input list_entry_t e [ENTRIES],
                                                   input logic [9:0] id);
        logic [IDX_W:0] r;
        r = '0;
        for (int i = 0; i < ENTRIES; i++) begin
            if (e[i].state[1] && e[i].virtual_id == id && !r[IDX_W]) begin
                r = {1'b1, IDX_W'(i)};
            end
        end
        return r;
    endfunction

    pending_select #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_select (
        .entries(lr_reg),
        .group_enable({ctl_reg[BIT_GROUP1_EN], ctl_reg[BIT_GROUP0_EN]}),
        .hit(sel_hit),
        .index(sel_idx),
        .group(sel_group)
    );

    assign sel_id = lr_reg[sel_idx].virtual_id;
    assign eoi_wr = reg_wr_en && (reg_addr == OFS_END_OF_INT || reg_addr == OFS_ALIASED_EOI);
    assign dir_wr = reg_wr_en && reg_addr == OFS_DEACTIVATE;
    assign ack_rd = reg_rd_en && reg_addr == OFS_ACKNOWLEDGE;
    assign {match_hit, match_idx} = find_active(lr_reg, reg_wdata[9:0]);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        ctl_next = ctl_reg;
        bp_next = bp_reg;
        abp_next = abp_reg;
        lr_next = lr_reg;
        held_next = held_reg;
        rdata_next = 32'h0000_0000;
        rvalid_next = reg_rd_en;
        cmp_next = '0;
        if (reg_wr_en && reg_addr == OFS_CONTROL) begin
            ctl_next = reg_wdata & CONTROL_WRITE_MASK;
        end
        if (reg_wr_en && reg_addr == OFS_BINARY_POINT) begin
            bp_next = (reg_wdata[2:0] < BP_MIN) ? BP_MIN : reg_wdata[2:0];
        end
        if (reg_wr_en && reg_addr == OFS_ALIASED_BP) begin
            abp_next = (reg_wdata[2:0] < ABP_MIN) ? ABP_MIN : reg_wdata[2:0];
        end
        if (eoi_wr && match_hit) begin
            held_next[match_idx] = 1'b0;
            if (!ctl_reg[BIT_SPLIT_EOI]) begin
                lr_next[match_idx].state = lr_reg[match_idx].state & LR_PENDING;
                cmp_next.valid = 1'b1;
                cmp_next.hw = lr_reg[match_idx].hw;
                cmp_next.id = lr_reg[match_idx].hw ? lr_reg[match_idx].physical_id :
                              lr_reg[match_idx].virtual_id;
            end
        end
        // guest ordering of deactivate after end-of-interrupt is trusted
        if (dir_wr && match_hit && ctl_reg[BIT_SPLIT_EOI]) begin
            lr_next[match_idx].state = lr_reg[match_idx].state & LR_PENDING;
            cmp_next.valid = 1'b1;
            cmp_next.hw = lr_reg[match_idx].hw;
            cmp_next.id = lr_reg[match_idx].hw ? lr_reg[match_idx].physical_id :
                          lr_reg[match_idx].virtual_id;
        end
        if (reg_rd_en) begin
            case (reg_addr)
                OFS_CONTROL: rdata_next = ctl_reg & CONTROL_WRITE_MASK;
                OFS_BINARY_POINT: rdata_next = {29'h0000_0000, bp_reg};
                OFS_ALIASED_BP: rdata_next = {29'h0000_0000, abp_reg};
                OFS_ACKNOWLEDGE: begin
                    if (!sel_hit) begin
                        rdata_next = {22'h00_0000, ID_SPURIOUS};
                    end else if (sel_group && !ctl_reg[BIT_ACK_CTL]) begin
                        rdata_next = {22'h00_0000, ID_GROUP1_HELD};
                    end else begin
                        rdata_next = {22'h00_0000, sel_id};
                        lr_next[sel_idx].state = LR_ACTIVE;
                        held_next[sel_idx] = 1'b1;
                    end
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        if (lr_load) begin
            lr_next[lr_index] = lr_data;
            if (lr_data.hw && lr_data.state == LR_ACT_PEND) begin
                lr_next[lr_index].state = LR_ACTIVE;
            end
            held_next[lr_index] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // signalling next state
    // ------------------------------------------------------------
    always_comb begin
        lr_rd_next = lr_reg[lr_rd_index];
        // selector only sees enabled groups
        virq_next = sel_hit && (sel_group || !ctl_reg[BIT_FAST_SEL]);
        vfiq_next = sel_hit && !sel_group && ctl_reg[BIT_FAST_SEL];
        g0bp_next = bp_reg;
        g1bp_next = ctl_reg[BIT_SHARED_BP] ? bp_reg : abp_reg;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_reg <= CONTROL_RESET;
            bp_reg <= BP_RESET;
            abp_reg <= ABP_RESET;
            for (int i = 0; i < ENTRIES; i++) begin
                lr_reg[i] <= '0;
            end
            held_reg <= '0;
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
            lr_rd_reg <= '0;
            virq_reg <= 1'b0;
            vfiq_reg <= 1'b0;
            g0bp_reg <= BP_RESET;
            g1bp_reg <= ABP_RESET;
            cmp_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
            bp_reg <= bp_next;
            abp_reg <= abp_next;
            lr_reg <= lr_next;
            held_reg <= held_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
            lr_rd_reg <= lr_rd_next;
            virq_reg <= virq_next;
            vfiq_reg <= vfiq_next;
            g0bp_reg <= g0bp_next;
            g1bp_reg <= g1bp_next;
            cmp_reg <= cmp_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign reg_rvalid = rvalid_reg;
    assign lr_rd_data = lr_rd_reg;
    assign virq = virq_reg;
    assign vfiq = vfiq_reg;
    assign group0_bp = g0bp_reg;
    assign group1_bp = g1bp_reg;
    assign completion = cmp_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_ctl_reserved: assert property (ctl_reg == (ctl_reg & CONTROL_WRITE_MASK))
        else $error("reserved control bits set");
    chk_ctl_readback: assert property (
        reg_rd_en && reg_addr == OFS_CONTROL |=> reg_rdata[31:10] == '0 && reg_rdata[8:5] == '0)
        else $error("reserved control bits read back");
    chk_spurious_read: assert property (
        ack_rd && !sel_hit |=> reg_rdata == 32'h0000_03FF)
        else $error("spurious id not returned");
    chk_group1_held: assert property (
        ack_rd && sel_hit && sel_group && !ctl_reg[BIT_ACK_CTL]
        |=> reg_rdata == 32'h0000_03FE && rvalid_reg)
        else $error("group 1 held id not returned");
    chk_held_untouched: assert property (
        ack_rd && sel_hit && sel_group && !ctl_reg[BIT_ACK_CTL] && !lr_load
        |=> lr_reg[$past(sel_idx)] == $past(lr_reg[sel_idx]))
        else $error("group 1 held entry changed");
    chk_group1_ack: assert property (
        ack_rd && sel_hit && sel_group && ctl_reg[BIT_ACK_CTL] && !lr_load
        |=> reg_rdata[9:0] == $past(sel_id) && lr_reg[$past(sel_idx)].state[1])
        else $error("group 1 acknowledge failed");
    chk_fast_route: assert property (
        vfiq |-> $past(ctl_reg[BIT_FAST_SEL]) && !$past(sel_group))
        else $error("fiq without fast select");
    chk_irq_route: assert property (
        virq && !$past(sel_group) |-> !$past(ctl_reg[BIT_FAST_SEL]))
        else $error("group 0 irq with fast select");
    chk_group1_gate: assert property (
        virq && $past(sel_group) |-> $past(ctl_reg[BIT_GROUP1_EN]))
        else $error("group 1 signalled while disabled");
    chk_group0_gate: assert property (
        (virq || vfiq) && !$past(sel_group) |-> $past(ctl_reg[BIT_GROUP0_EN]))
        else $error("group 0 signalled while disabled");
    chk_split_eoi: assert property (
        eoi_wr && ctl_reg[BIT_SPLIT_EOI] && !dir_wr |=> !completion.valid)
        else $error("split end-of-interrupt deactivated");
    chk_split_keep: assert property (
        eoi_wr && match_hit && ctl_reg[BIT_SPLIT_EOI] && !lr_load
        |=> lr_reg[$past(match_idx)].state[1] && !held_reg[$past(match_idx)])
        else $error("split end-of-interrupt changed entry state");
    chk_combined_eoi: assert property (
        eoi_wr && match_hit && !ctl_reg[BIT_SPLIT_EOI]
        |=> completion.valid && !held_reg[$past(match_idx)])
        else $error("combined end-of-interrupt missed completion");
    // a deactivate with no write after it gives a single one-cycle completion pulse
    chk_dir_complete: assert property (
        dir_wr && match_hit && ctl_reg[BIT_SPLIT_EOI] ##1 !(dir_wr || eoi_wr)
        |-> completion.valid ##1 !completion.valid)
        else $error("deactivate completion not one pulse");
    chk_dir_inactive: assert property (
        dir_wr && match_hit && ctl_reg[BIT_SPLIT_EOI] && !lr_load
        |=> !lr_reg[$past(match_idx)].state[1])
        else $error("deactivate left entry active");
    chk_dir_ignored: assert property (
        dir_wr && !ctl_reg[BIT_SPLIT_EOI] |=> !completion.valid)
        else $error("deactivate acted in combined mode");
    chk_bp_share: assert property (
        group1_bp == ($past(ctl_reg[BIT_SHARED_BP]) ? $past(bp_reg) : $past(abp_reg)))
        else $error("group 1 binary point wrong");
    chk_bp_main: assert property (group0_bp == $past(bp_reg))
        else $error("group 0 binary point wrong");

    for (genvar g = 0; g < ENTRIES; g++) begin : g_hw_chk
        chk_hw_actpend: assert property (
            !(lr_reg[g].hw && lr_reg[g].state == LR_ACT_PEND))
            else $error("hardware entry active and pending");
    end

    // ------------------------------------------------------------
    // cover points
    // ------------------------------------------------------------
    cov_ack_taken: cover property (ack_rd && sel_hit && !sel_group ##1 rvalid_reg);
    cov_group1_held: cover property (ack_rd && sel_hit && sel_group && !ctl_reg[BIT_ACK_CTL]);
    cov_split_flow: cover property (eoi_wr && ctl_reg[BIT_SPLIT_EOI] ##[1:20] dir_wr && match_hit);
    cov_fiq_raised: cover property (vfiq);
    cov_dir_done: cover property (dir_wr && match_hit ##1 completion.valid && completion.hw);

endmodule

/* File: dv/far_side_model.sv */
// far side model: hypervisor list loader and distributor completion sink
module far_side_model
    import vcpu_ctl_pkg::*;
#(
    parameter int IDX_W = 2
) (
    // clock
    input wire logic core_clk,
    // list port
    output logic lr_load,
    output logic [IDX_W-1:0] lr_index,
    output list_entry_t lr_data,
    // distributor side
    input wire completion_t completion
);
    timeunit 1ns;
    timeprecision 1ps;
    int comp_count = 0;
    completion_t last_comp = '0;
    initial begin
        lr_load = 1'b0;
        lr_index = '0;
        lr_data = '0;
    end
    // counts completion pulses and keeps the last one
    always @(posedge core_clk) begin
        if (completion.valid === 1'b1) begin
            comp_count <= comp_count + 1;
            last_comp <= completion;
        end
    end
    // one entry load; released lines show the inverse value
    task automatic load(input logic [IDX_W-1:0] idx, input list_entry_t e);
        @(posedge core_clk);
        lr_load <= 1'b1;
        lr_index <= idx;
        lr_data <= e;
        @(posedge core_clk);
        lr_load <= 1'b0;
        lr_index <= ~idx;
        lr_data <= ~e;
    endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the virtual cpu interface control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import vcpu_ctl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [12:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic lr_load;
    logic [1:0] lr_index;
    list_entry_t lr_data;
    logic [1:0] lr_rd_index = '0;
    list_entry_t lr_rd_data;
    logic virq;
    logic vfiq;
    logic [2:0] group0_bp;
    logic [2:0] group1_bp;
    completion_t completion;
    int bad_count = 0;
    int n_checks = 0;
    int c;

    virtual_cpu_if_control #(.ENTRIES(4)) virtual_cpu_if_control_inst (
        .core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .lr_load(lr_load), .lr_index(lr_index), .lr_data(lr_data),
        .lr_rd_index(lr_rd_index), .lr_rd_data(lr_rd_data), .virq(virq), .vfiq(vfiq),
        .group0_bp(group0_bp), .group1_bp(group1_bp), .completion(completion));
    far_side_model #(.IDX_W(2)) far_side_model_inst (
        .core_clk(core_clk), .lr_load(lr_load), .lr_index(lr_index), .lr_data(lr_data),
        .completion(completion));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    // --------------------------------------------------------
    // access tasks
    // --------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr_en <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [31:0] exp);
        int i;
        @(posedge core_clk);
        reg_rd_en <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        if (reg_rvalid !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t read answer missing", $time);
            results();
        end
        chk(reg_rdata, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask
    task automatic lr_chk(input logic [1:0] idx, input logic [1:0] st);
        @(posedge core_clk);
        lr_rd_index <= idx;
        settle();
        chk({30'h0, lr_rd_data.state}, {30'h0, st});
    endtask
    function automatic list_entry_t ent(input logic hw, input logic grp, input logic [1:0] st,
                                        input logic [9:0] pid, input logic [9:0] vid);
        ent = {hw, grp, st, 5'h04, pid, vid};
    endfunction

    // --------------------------------------------------------
    // test sequence
    // --------------------------------------------------------
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        rd(OFS_CONTROL, 32'h0000_0000);
        rd(OFS_BINARY_POINT, 32'h0000_0002);
        rd(OFS_ALIASED_BP, 32'h0000_0003);
        rd(OFS_ACKNOWLEDGE, 32'h0000_03FF);
        rd(13'h0100, 32'h0000_0000);
        wr(OFS_CONTROL, 32'hFFFF_FFFF);
        rd(OFS_CONTROL, 32'h0000_021F);
        wr(OFS_CONTROL, 32'h0000_0000);
        $display("test reset and reserved bits done");
        wr(OFS_BINARY_POINT, 32'h0000_0000);
        rd(OFS_BINARY_POINT, 32'h0000_0002);
        wr(OFS_BINARY_POINT, 32'h0000_0005);
        wr(OFS_ALIASED_BP, 32'h0000_0006);
        settle();
        chk({26'h0, group0_bp, group1_bp}, 32'h0000_002E);
        wr(OFS_CONTROL, 32'h0000_0010);
        settle();
        chk({26'h0, group0_bp, group1_bp}, 32'h0000_002D);
        $display("test binary point done");
        wr(OFS_CONTROL, 32'h0000_0000);
        far_side_model_inst.load(2'd0, ent(1'b0, 1'b0, LR_PENDING, 10'h000, 10'h021));
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0000);
        rd(OFS_ACKNOWLEDGE, 32'h0000_03FF);
        wr(OFS_CONTROL, 32'h0000_0001);
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0001);
        wr(OFS_CONTROL, 32'h0000_0009);
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0002);
        $display("test group 0 signalling done");
        far_side_model_inst.load(2'd0, ent(1'b0, 1'b1, LR_PENDING, 10'h000, 10'h021));
        wr(OFS_CONTROL, 32'h0000_0001);
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0000);
        wr(OFS_CONTROL, 32'h0000_0002);
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0001);
        wr(OFS_CONTROL, 32'h0000_000A);
        settle();
        chk({30'h0, vfiq, virq}, 32'h0000_0001);
        wr(OFS_CONTROL, 32'h0000_0002);
        rd(OFS_ACKNOWLEDGE, 32'h0000_03FE);
        lr_chk(2'd0, LR_PENDING);
        wr(OFS_CONTROL, 32'h0000_0006);
        rd(OFS_ACKNOWLEDGE, 32'h0000_0021);
        lr_chk(2'd0, LR_ACTIVE);
        wr(OFS_CONTROL, 32'h0000_0002);
        $display("test group 1 acknowledge done");
        c = far_side_model_inst.comp_count;
        wr(OFS_END_OF_INT, 32'h0000_0021);
        settle();
        chk(far_side_model_inst.comp_count, c + 1);
        chk({20'h0, far_side_model_inst.last_comp}, 32'h0000_0821);
        lr_chk(2'd0, LR_INVALID);
        $display("test combined end of interrupt done");
        far_side_model_inst.load(2'd1, ent(1'b1, 1'b0, LR_PENDING, 10'h155, 10'h044));
        wr(OFS_CONTROL, 32'h0000_0201);
        rd(OFS_ACKNOWLEDGE, 32'h0000_0044);
        c = far_side_model_inst.comp_count;
        wr(OFS_ALIASED_EOI, 32'h0000_0044);
        settle();
        chk(far_side_model_inst.comp_count, c);
        lr_chk(2'd1, LR_ACTIVE);
        wr(OFS_DEACTIVATE, 32'h0000_0044);
        settle();
        chk(far_side_model_inst.comp_count, c + 1);
        chk({20'h0, far_side_model_inst.last_comp}, 32'h0000_0D55);
        lr_chk(2'd1, LR_INVALID);
        $display("test split end of interrupt done");
        far_side_model_inst.load(2'd2, ent(1'b1, 1'b0, LR_ACT_PEND, 10'h0AA, 10'h055));
        lr_chk(2'd2, LR_ACTIVE);
        far_side_model_inst.load(2'd3, ent(1'b0, 1'b0, LR_ACT_PEND, 10'h000, 10'h066));
        lr_chk(2'd3, LR_ACT_PEND);
        $display("test active and pending done");
        wr(OFS_CONTROL, 32'h0000_0001);
        c = far_side_model_inst.comp_count;
        wr(OFS_DEACTIVATE, 32'h0000_0055);
        wr(OFS_END_OF_INT, 32'h0000_03FF);
        settle();
        chk(far_side_model_inst.comp_count, c);
        lr_chk(2'd2, LR_ACTIVE);
        wr(OFS_END_OF_INT, 32'h0000_0066);
        settle();
        chk(far_side_model_inst.comp_count, c + 1);
        chk({20'h0, far_side_model_inst.last_comp}, 32'h0000_0866);
        lr_chk(2'd3, LR_PENDING);
        rd(OFS_ACKNOWLEDGE, 32'h0000_0066);
        lr_chk(2'd3, LR_ACTIVE);
        $display("test combined mode deactivate done");
        results();
    end

    initial begin
        #2ms;
        bad_count++;
        $display("[FAIL] %0t run timed out", $time);
        results();
    end
endmodule
